// ---- bench/lucr_host_model.sv ----
// two-wire host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module lucr_host_model (
	input wire logic clk,
	input wire logic sda_line,
	output var logic scl,
	output var logic sda_low
);
	// bus idles released, scl stands high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// sda only moves two cycles after scl falls, clear of the filter lag
	task automatic bitx(input logic b, output logic r);
		w(2);
		sda_low = !b;
		w(8);
		scl = 1'b1;
		w(5);
		r = sda_line;
		w(5);
		scl = 1'b0;
	endtask
	task automatic start();
		w(2);
		sda_low = 1'b0;
		w(8);
		scl = 1'b1;
		w(10);
		sda_low = 1'b1;
		w(10);
		scl = 1'b0;
	endtask
	task automatic stop();
		w(2);
		sda_low = 1'b1;
		w(8);
		scl = 1'b1;
		w(10);
		sda_low = 1'b0;
		w(10);
	endtask
	task automatic sbyte(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ok = ok & !r;
	endtask
	task automatic reg_write(input logic [6:0] a, input logic [7:0] o, d,
		output logic ok);
		ok = 1'b1;
		start();
		sbyte({a, 1'b0}, ok);
		sbyte(o, ok);
		sbyte(d, ok);
		stop();
	endtask
	task automatic reg_read(input logic [6:0] a, input logic [7:0] o,
		output logic [7:0] d, output logic ok);
		logic r;
		ok = 1'b1;
		start();
		sbyte({a, 1'b0}, ok);
		sbyte(o, ok);
		start();
		sbyte({a, 1'b1}, ok);
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(1'b1, r);
		stop();
	endtask
endmodule
`default_nettype wire

// ---- bench/lucr_props.sv ----
// assertion checker for the lighting control register bank
`timescale 1ns/1ps
`default_nettype none
module lucr_props (
	input wire logic                 clk,
	input wire logic                 srst,
	input wire logic                 ext_reset_n,
	input wire logic                 scl_in,
	input wire logic                 ext_pwm_in,
	input wire logic                 sda_out,
	input wire logic                 sda_oe,
	input wire logic [2:0]           gpio_out,
	input wire logic [2:0]           gpio_oe,
	input wire lucr_pkg::lucr_byte_t main_current_code,
	input wire logic                 shared_display_drive,
	input wire lucr_pkg::lucr_byte_t primary_drive_code_q,
	input wire lucr_pkg::lucr_byte_t secondary_drive_code_q,
	input wire lucr_pkg::lucr_byte_t boost_target_code_q,
	input wire logic                 active_not_standby,
	input wire logic                 boost_enable,
	input wire logic                 converter_dummy_load_on,
	input wire logic                 keypad_sink_one_allow,
	input wire logic                 keypad_sink_two_allow,
	input wire logic                 keypad_sink_three_allow,
	input wire logic                 primary_display_allow,
	input wire logic                 secondary_display_allow
);
	import lucr_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wire logic [4:0] allow = {keypad_sink_one_allow, keypad_sink_two_allow,
		keypad_sink_three_allow, primary_display_allow, secondary_display_allow};
	sda_never_high_a: assert property (sda_out == 1'b0)
		else $error("sda driven high");
	reset_pins_a: assert property ($fell(srst) |-> gpio_oe == 3'h0 && gpio_out == 3'h0)
		else $error("pin registers not cleared by reset");
	reset_power_a: assert property ($fell(srst) |-> !active_not_standby && !boost_enable
		&& converter_dummy_load_on && boost_target_code_q == 8'h08)
		else $error("power registers wrong after reset");
	primary_follow_a: assert property (!$past(srst) |-> primary_drive_code_q == $past(main_current_code))
		else $error("primary code not following main code");
	shared_drive_a: assert property ($past(shared_display_drive) && !$past(srst)
		|-> secondary_drive_code_q == $past(main_current_code))
		else $error("shared mode ignores main code");
	pwm_high_allow_a: assert property (ext_pwm_in [*6] |-> allow == 5'h1f)
		else $error("outputs blocked while dimming pin high");
	ack_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda changed while scl high");
	reg_update_a: assert property (disable iff (srst || !ext_reset_n)
		$changed(boost_target_code_q) || $changed(gpio_oe) |-> !scl_in)
		else $error("register changed outside a write");
	cover property ($rose(sda_oe));
	cover property (allow == 5'h00);
	cover property (shared_display_drive && main_current_code != 8'h00);
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the lighting control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lucr_pkg::*;
	localparam logic [6:0] ADR = 7'h2a;
	logic clk, srst, ext_reset_n, scl_in, sda_low, ext_pwm_in, sda_out;
	logic sda_oe, shared_display_drive, active_not_standby, boost_enable;
	logic converter_dummy_load_on, keypad_sink_one_allow, keypad_sink_two_allow;
	logic keypad_sink_three_allow, primary_display_allow, secondary_display_allow;
	logic [2:0] gpio_in, gpio_out, gpio_oe;
	lucr_byte_t main_current_code, primary_drive_code_q, secondary_drive_code_q;
	lucr_byte_t boost_target_code_q, mdl[256], o, d;
	lucr_byte_t ofs_l[7] = '{8'h05, 8'h06, 8'h07, 8'h0b, 8'h0d, 8'h2b, 8'h08};
	int n_errors = 0, checked = 0, cyc = 0, seed = 5221;
	wire sda_in = !(sda_low | (sda_oe & !sda_out));
	wire [4:0] allow = {keypad_sink_one_allow, keypad_sink_two_allow,
		keypad_sink_three_allow, primary_display_allow, secondary_display_allow};
	lucr_ctrl_regs uut (.clk, .srst, .ext_reset_n, .scl_in, .sda_in, .sda_out,
		.sda_oe, .ext_pwm_in, .gpio_in, .gpio_out, .gpio_oe, .main_current_code,
		.shared_display_drive, .primary_drive_code_q, .secondary_drive_code_q,
		.boost_target_code_q, .active_not_standby, .boost_enable,
		.converter_dummy_load_on, .keypad_sink_one_allow, .keypad_sink_two_allow,
		.keypad_sink_three_allow, .primary_display_allow, .secondary_display_allow);
	lucr_host_model host (.clk, .sda_line(sda_in), .scl(scl_in), .sda_low);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			$display("BAD timeout");
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input lucr_byte_t e, g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	function automatic lucr_byte_t msk(lucr_byte_t a);
		case (a)
		OFS_SUB_CURRENT: return MSK_SUB_CURRENT;
		OFS_PIN_DIRECTION: return MSK_PIN_DIRECTION;
		OFS_PIN_DATA: return MSK_PIN_DATA;
		OFS_POWER_ENABLES: return MSK_POWER_ENABLES;
		OFS_BOOST_VOLTAGE: return MSK_BOOST_VOLTAGE;
		OFS_EXT_PWM_GATES: return MSK_EXT_PWM_GATES;
		default: return 8'h00;
		endcase
	endfunction
	task automatic reset_mdl();
		foreach (mdl[i]) mdl[i] = 8'h00;
		mdl[8'h0b] = 8'h04;
		mdl[8'h0d] = 8'h08;
	endtask
	task automatic wr(input lucr_byte_t a, v);
		logic ok;
		host.reg_write(ADR, a, v, ok);
		chk("wr_ack", 8'h01, {7'h00, ok});
		mdl[a] = v & msk(a);
	endtask
	task automatic rdchk(input lucr_byte_t a);
		logic ok;
		lucr_byte_t v;
		host.reg_read(ADR, a, v, ok);
		chk("rd_ack", 8'h01, {7'h00, ok});
		chk("rd", mdl[a], v);
	endtask
	task automatic outs();
		chk("pins", {2'b0, mdl[6][2:0], mdl[7][2:0]}, {2'b0, gpio_oe, gpio_out});
		chk("power", {5'b0, mdl[11][6], mdl[11][5], mdl[11][2]},
			{5'b0, active_not_standby, boost_enable, converter_dummy_load_on});
		chk("boost", mdl[13], boost_target_code_q);
		chk("sub", mdl[5], secondary_drive_code_q);
	endtask
	initial begin
		{srst, ext_reset_n, ext_pwm_in, shared_display_drive} = 4'b1100;
		main_current_code = 8'h00;
		gpio_in = 3'h5;
		reset_mdl();
		repeat (3) @(posedge clk);
		#1 srst = 1'b0;
		host.w(6);
		foreach (ofs_l[i]) rdchk(ofs_l[i]);
		outs();
		$display("test reset values done");
		// all ones shows reserved bits dropping; boost kept at its top code
		foreach (ofs_l[i]) begin
			wr(ofs_l[i], ofs_l[i] == OFS_BOOST_VOLTAGE ? 8'h12 : 8'hff);
			rdchk(ofs_l[i]);
		end
		outs();
		for (int i = 0; i < 12; i++) begin
			o = ofs_l[$unsigned($random(seed)) % 7];
			d = 8'($random(seed));
			if (o == OFS_BOOST_VOLTAGE) d = 8'(8 + $unsigned($random(seed)) % 11);
			gpio_in = 3'($random(seed));
			wr(o, d);
			rdchk(o);
		end
		outs();
		$display("test register access done");
		wr(OFS_PIN_DIRECTION, 8'h10);
		for (int i = 0; i < 5; i++) begin
			wr(OFS_EXT_PWM_GATES, 8'h01 << i);
			ext_pwm_in = 1'b0;
			host.w(6);
			chk("gated", ~(8'h01 << i) & 8'h1f, {3'b0, allow});
			ext_pwm_in = 1'b1;
			host.w(6);
			chk("pwm_high", 8'h1f, {3'b0, allow});
		end
		wr(OFS_EXT_PWM_GATES, 8'h1f);
		wr(OFS_PIN_DIRECTION, 8'h00);
		ext_pwm_in = 1'b0;
		host.w(6);
		chk("pin_off", 8'h1f, {3'b0, allow});
		$display("test dimming gates done");
		main_current_code = 8'($random(seed));
		shared_display_drive = 1'b1;
		host.w(3);
		chk("main", main_current_code, primary_drive_code_q);
		chk("shared", main_current_code, secondary_drive_code_q);
		shared_display_drive = 1'b0;
		main_current_code = 8'h00;
		host.w(3);
		chk("sub", mdl[5], secondary_drive_code_q);
		$display("test shared drive done");
		host.reg_write(ADR ^ 7'h01, OFS_SUB_CURRENT, 8'h5a, d[0]);
		chk("nack", 8'h00, {7'h00, d[0]});
		rdchk(OFS_SUB_CURRENT);
		ext_reset_n = 1'b0;
		host.w(8);
		ext_reset_n = 1'b1;
		host.w(8);
		reset_mdl();
		foreach (ofs_l[i]) rdchk(ofs_l[i]);
		wr(OFS_POWER_ENABLES, 8'h60);
		outs();
		srst = 1'b1;
		host.w(2);
		srst = 1'b0;
		host.w(6);
		reset_mdl();
		outs();
		$display("test resets done");
		finish_test();
	end
endmodule
bind lucr_ctrl_regs lucr_props chk_i (.clk, .srst, .ext_reset_n, .scl_in,
	.ext_pwm_in, .sda_out, .sda_oe, .gpio_out, .gpio_oe, .main_current_code,
	.shared_display_drive, .primary_drive_code_q, .secondary_drive_code_q,
	.boost_target_code_q, .active_not_standby, .boost_enable,
	.converter_dummy_load_on, .keypad_sink_one_allow, .keypad_sink_two_allow,
	.keypad_sink_three_allow, .primary_display_allow, .secondary_display_allow);
`default_nettype wire

// ---- inc/lucr_pkg.sv ----
// constants and types shared by the lighting control register bank
package lucr_pkg;

	typedef logic [7:0] lucr_byte_t;

	// register offsets
	localparam lucr_byte_t OFS_SUB_CURRENT   = 8'h05;
	localparam lucr_byte_t OFS_PIN_DIRECTION = 8'h06;
	localparam lucr_byte_t OFS_PIN_DATA      = 8'h07;
	localparam lucr_byte_t OFS_POWER_ENABLES = 8'h0b;
	localparam lucr_byte_t OFS_BOOST_VOLTAGE = 8'h0d;
	localparam lucr_byte_t OFS_EXT_PWM_GATES = 8'h2b;

	// field positions
	localparam int POS_PWM_PIN_EN   = 4;
	localparam int POS_PIN_DIR_LSB  = 0;
	localparam int POS_PIN_DATA_LSB = 0;
	localparam int POS_ACTIVE       = 6;
	localparam int POS_BOOST_EN     = 5;
	localparam int POS_DUMMY_LOAD   = 2;
	localparam int POS_EXT_K1       = 4;
	localparam int POS_EXT_K2       = 3;
	localparam int POS_EXT_K3       = 2;
	localparam int POS_EXT_PRIMARY  = 1;
	localparam int POS_EXT_SECOND   = 0;

	// widths
	localparam int GPIO_W     = 3;
	localparam int I2C_ADDR_W = 7;

	// reset values
	localparam lucr_byte_t RST_SUB_CURRENT   = 8'h00;
	localparam lucr_byte_t RST_PIN_DIRECTION = 8'h00;
	localparam lucr_byte_t RST_PIN_DATA      = 8'h00;
	localparam lucr_byte_t RST_POWER_ENABLES = 8'h04;
	localparam lucr_byte_t RST_BOOST_VOLTAGE = 8'h08;
	localparam lucr_byte_t RST_EXT_PWM_GATES = 8'h00;

	// writable-bit masks; everything else stores nothing and reads zero
	localparam lucr_byte_t MSK_SUB_CURRENT   = 8'hff;
	localparam lucr_byte_t MSK_PIN_DIRECTION = 8'h17;
	localparam lucr_byte_t MSK_PIN_DATA      = 8'h07;
	localparam lucr_byte_t MSK_POWER_ENABLES = 8'h64;
	localparam lucr_byte_t MSK_BOOST_VOLTAGE = 8'hff;
	localparam lucr_byte_t MSK_EXT_PWM_GATES = 8'h1f;

	// serial port engine states, one-hot
	typedef enum logic [8:0] {
		ST_IDLE      = 9'h001,
		ST_ADDR      = 9'h002,
		ST_ADDR_ACK  = 9'h004,
		ST_PTR       = 9'h008,
		ST_PTR_ACK   = 9'h010,
		ST_WDATA     = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA     = 9'h080,
		ST_RDATA_ACK = 9'h100
	} lucr_state_t;

endpackage

// ---- rtl/lucr_ctrl_regs.sv ----
// upper control register bank behind the two-wire serial port
// What this block does
// - secondary display current code, 0.1 mA per step, zero gives none.
// - primary display code uses the same linear 0.1 mA table.
// - external dimming pin counts only while its enable bit 4 is set.
// - bits 2..0 set each general pin direction, one means output.
// - data register holds one bit per pin; upper bits read zero.
// - bit 6 of enables leaves standby when set.
// - bit 5 of enables turns the boost converter on.
// - bit 2 of enables turns the dummy load on; resets to one.
// - boost target code, one volt per step, 8 V to 18 V, resets 8 V.
// - gate bit 4 lets the external pin dim keypad sink one.
// - gate bit 3 lets the external pin dim keypad sink two.
// - gate bit 2 lets the external pin dim keypad sink three.
// - gate bit 1 lets the external pin dim the primary display.
// - gate bit 0 lets the external pin dim the secondary display.
// - shared display mode drives both displays from the primary code.
`timescale 1ns/1ps
`default_nettype none

module lucr_ctrl_regs #(
	// bus address, arbitrary value
	parameter logic [lucr_pkg::I2C_ADDR_W-1:0] DEV_ADDR = 7'h2a
) (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       ext_reset_n,
	input  wire logic                       scl_in,
	input  wire logic                       sda_in,
	output var  logic                       sda_out,
	output var  logic                       sda_oe,
	input  wire logic                       ext_pwm_in,
	input  wire logic [lucr_pkg::GPIO_W-1:0] gpio_in,
	output var  logic [lucr_pkg::GPIO_W-1:0] gpio_out,
	output var  logic [lucr_pkg::GPIO_W-1:0] gpio_oe,
	input  wire lucr_pkg::lucr_byte_t        main_current_code,
	input  wire logic                       shared_display_drive,
	output var  lucr_pkg::lucr_byte_t        primary_drive_code_q,
	output var  lucr_pkg::lucr_byte_t        secondary_drive_code_q,
	output var  lucr_pkg::lucr_byte_t        boost_target_code_q,
	output var  logic                       active_not_standby,
	output var  logic                       boost_enable,
	output var  logic                       converter_dummy_load_on,
	output var  logic                       keypad_sink_one_allow,
	output var  logic                       keypad_sink_two_allow,
	output var  logic                       keypad_sink_three_allow,
	output var  logic                       primary_display_allow,
	output var  logic                       secondary_display_allow
);

	import lucr_pkg::*;

	// pin conditioning
	logic [3:0] pins_raw;
	logic [3:0] pins_q;
	logic       scl_f;
	logic       sda_f;
	logic       pwm_f;
	logic       nrst_f;

	assign pins_raw = {ext_reset_n, ext_pwm_in, sda_in, scl_in};

	lucr_pin_sync #(
		.W       (4),
		.RST_VAL (4'hb)
	) u_sync (
		.clk     (clk),
		.srst    (srst),
		.pin_in  (pins_raw),
		.level_q (pins_q)
	);

	assign scl_f  = pins_q[0];
	assign sda_f  = pins_q[1];
	assign pwm_f  = pins_q[2];
	assign nrst_f = pins_q[3];

	// external reset pin clears the registers like power-on does
	logic rst;
	assign rst = srst | ~nrst_f;

	// bus edge and condition detection on filtered levels
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	always_ff @(posedge clk) begin
		if (srst) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_f;
			sda_prev_q <= sda_f;
		end
	end

	assign scl_rise  = scl_f & ~scl_prev_q;
	assign scl_fall  = ~scl_f & scl_prev_q;
	assign bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
	assign bus_stop  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

	// register storage
	lucr_byte_t sub_code_q;
	lucr_byte_t pin_dir_q;
	lucr_byte_t pin_data_q;
	lucr_byte_t enables_q;
	lucr_byte_t boost_code_q;
	lucr_byte_t pwm_gates_q;

	function automatic logic hit(input lucr_byte_t a, input lucr_byte_t ofs);
		hit = (a == ofs);
	endfunction

	// serial engine state
	lucr_state_t state_q;
	logic [3:0]  bit_cnt_q;
	lucr_byte_t  rx_q;
	lucr_byte_t  tx_q;
	lucr_byte_t  ptr_q;
	logic        rd_mode_q;
	logic        master_nack_q;
	logic        oe_q;

	// read mux; unmapped offsets answer zero
	lucr_byte_t rd_data;
	assign rd_data =
		hit(ptr_q, OFS_SUB_CURRENT)   ? sub_code_q   :
		hit(ptr_q, OFS_PIN_DIRECTION) ? pin_dir_q    :
		hit(ptr_q, OFS_PIN_DATA)      ? pin_data_q   :
		hit(ptr_q, OFS_POWER_ENABLES) ? enables_q    :
		hit(ptr_q, OFS_BOOST_VOLTAGE) ? boost_code_q :
		hit(ptr_q, OFS_EXT_PWM_GATES) ? pwm_gates_q  : 8'h00;

	logic byte_done;
	logic addr_match;
	logic wr_fire;
	lucr_byte_t rx_next;

	assign byte_done  = (bit_cnt_q == 4'h8);
	assign addr_match = (rx_q[7:1] == DEV_ADDR);
	assign wr_fire    = scl_fall & (state_q == ST_WDATA) & byte_done;
	assign rx_next    = {rx_q[6:0], sda_f};

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q       <= ST_IDLE;
			bit_cnt_q     <= 4'h0;
			rx_q          <= 8'h00;
			tx_q          <= 8'h00;
			ptr_q         <= 8'h00;
			rd_mode_q     <= 1'b0;
			master_nack_q <= 1'b0;
			oe_q          <= 1'b0;
		end else if (bus_start) begin
			// repeated start keeps the pointer for a following read
			state_q   <= ST_ADDR;
			bit_cnt_q <= 4'h0;
			oe_q      <= 1'b0;
		end else if (bus_stop) begin
			state_q <= ST_IDLE;
			oe_q    <= 1'b0;
		end else if (scl_rise) begin
			case (state_q)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					rx_q      <= rx_next;
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end
				ST_RDATA_ACK: begin
					master_nack_q <= sda_f;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state_q)
				ST_ADDR: begin
					if (byte_done && addr_match) begin
						state_q   <= ST_ADDR_ACK;
						rd_mode_q <= rx_q[0];
						oe_q      <= 1'b1;
					end else if (byte_done) begin
						// another device is addressed; sit out the frame
						state_q <= ST_IDLE;
					end
				end
				ST_ADDR_ACK, ST_RDATA_ACK: begin
					if (state_q == ST_ADDR_ACK && !rd_mode_q) begin
						state_q   <= ST_PTR;
						bit_cnt_q <= 4'h0;
						oe_q      <= 1'b0;
					end else if (state_q == ST_RDATA_ACK && master_nack_q) begin
						state_q <= ST_IDLE;
						oe_q    <= 1'b0;
					end else begin
						// open drain: enable pulls low for a zero bit
						state_q   <= ST_RDATA;
						tx_q      <= {rd_data[6:0], 1'b0};
						oe_q      <= ~rd_data[7];
						bit_cnt_q <= 4'h1;
						ptr_q     <= ptr_q + 8'h01;
					end
				end
				ST_PTR: begin
					if (byte_done) begin
						state_q <= ST_PTR_ACK;
						ptr_q   <= rx_q;
						oe_q    <= 1'b1;
					end
				end
				ST_WDATA: begin
					if (byte_done) begin
						state_q <= ST_WDATA_ACK;
						oe_q    <= 1'b1;
					end
				end
				ST_PTR_ACK, ST_WDATA_ACK: begin
					if (state_q == ST_WDATA_ACK) begin
						ptr_q <= ptr_q + 8'h01;
					end
					state_q   <= ST_WDATA;
					bit_cnt_q <= 4'h0;
					oe_q      <= 1'b0;
				end
				ST_RDATA: begin
					if (byte_done) begin
						// release the line for the master's answer
						state_q <= ST_RDATA_ACK;
						oe_q    <= 1'b0;
					end else begin
						oe_q      <= ~tx_q[7];
						tx_q      <= {tx_q[6:0], 1'b0};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					oe_q    <= 1'b0;
				end
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = oe_q;

	// register writes; unused bits are masked off on the way in
	logic we_sub;
	logic we_dir;
	logic we_data;
	logic we_en;
	logic we_boost;
	logic we_gates;

	assign we_sub   = wr_fire & hit(ptr_q, OFS_SUB_CURRENT);
	assign we_dir   = wr_fire & hit(ptr_q, OFS_PIN_DIRECTION);
	assign we_data  = wr_fire & hit(ptr_q, OFS_PIN_DATA);
	assign we_en    = wr_fire & hit(ptr_q, OFS_POWER_ENABLES);
	assign we_boost = wr_fire & hit(ptr_q, OFS_BOOST_VOLTAGE);
	assign we_gates = wr_fire & hit(ptr_q, OFS_EXT_PWM_GATES);

	always_ff @(posedge clk) begin
		if (rst) begin
			sub_code_q   <= RST_SUB_CURRENT;
			pin_dir_q    <= RST_PIN_DIRECTION;
			pin_data_q   <= RST_PIN_DATA;
			enables_q    <= RST_POWER_ENABLES;
			boost_code_q <= RST_BOOST_VOLTAGE;
			pwm_gates_q  <= RST_EXT_PWM_GATES;
		end else begin
			if (we_sub) begin
				sub_code_q <= rx_q & MSK_SUB_CURRENT;
			end
			if (we_dir) begin
				pin_dir_q <= rx_q & MSK_PIN_DIRECTION;
			end
			if (we_data) begin
				pin_data_q <= rx_q & MSK_PIN_DATA;
			end
			if (we_en) begin
				enables_q <= rx_q & MSK_POWER_ENABLES;
			end
			if (we_boost) begin
				// out-of-span codes are stored as written
				boost_code_q <= rx_q & MSK_BOOST_VOLTAGE;
			end
			if (we_gates) begin
				pwm_gates_q <= rx_q & MSK_EXT_PWM_GATES;
			end
		end
	end

	// general-purpose pins; read data is the stored bit, not the pad
	assign gpio_oe  = pin_dir_q[POS_PIN_DIR_LSB +: GPIO_W];
	assign gpio_out = pin_data_q[POS_PIN_DATA_LSB +: GPIO_W];

	// enables to the analog side
	assign active_not_standby      = enables_q[POS_ACTIVE];
	assign boost_enable            = enables_q[POS_BOOST_EN];
	assign converter_dummy_load_on = enables_q[POS_DUMMY_LOAD];

	// external dimming: with pin enable bit 4 set, a gated output runs only while the pin is high
	logic pwm_level;
	logic ext_dim_keypad_one;
	logic ext_dim_keypad_two;
	logic ext_dim_keypad_three;
	logic ext_dim_primary_display;
	logic ext_dim_secondary_display;

	// disabled pin reads as high so gated outputs stay lit
	assign pwm_level = ~pin_dir_q[POS_PWM_PIN_EN] | pwm_f;

	assign ext_dim_keypad_one        = pwm_gates_q[POS_EXT_K1];
	assign ext_dim_keypad_two        = pwm_gates_q[POS_EXT_K2];
	assign ext_dim_keypad_three      = pwm_gates_q[POS_EXT_K3];
	assign ext_dim_primary_display   = pwm_gates_q[POS_EXT_PRIMARY];
	assign ext_dim_secondary_display = pwm_gates_q[POS_EXT_SECOND];

	assign keypad_sink_one_allow   = ~ext_dim_keypad_one | pwm_level;
	assign keypad_sink_two_allow   = ~ext_dim_keypad_two | pwm_level;
	assign keypad_sink_three_allow = ~ext_dim_keypad_three | pwm_level;
	assign primary_display_allow   =
		~ext_dim_primary_display | pwm_level;
	assign secondary_display_allow =
		~ext_dim_secondary_display | pwm_level;

	// drive codes and boost target, registered; drive code value is current in 0.1 mA units
	lucr_byte_t secondary_d;
	assign secondary_d = shared_display_drive ? main_current_code
	                                          : sub_code_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			primary_drive_code_q   <= RST_SUB_CURRENT;
			secondary_drive_code_q <= RST_SUB_CURRENT;
			boost_target_code_q    <= RST_BOOST_VOLTAGE;
		end else begin
			primary_drive_code_q   <= main_current_code;
			secondary_drive_code_q <= secondary_d;
			boost_target_code_q    <= boost_code_q;
		end
	end

endmodule

`default_nettype wire

// ---- rtl/lucr_pin_sync.sv ----
// three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
`default_nettype none

module lucr_pin_sync #(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] pin_in,
	output var  logic [W-1:0] level_q
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			// s1 feeds only s2; the filter looks at s2 and s3
			always_ff @(posedge clk) begin
				if (srst) begin
					s1_q       <= RST_VAL[i];
					s2_q       <= RST_VAL[i];
					s3_q       <= RST_VAL[i];
					level_q[i] <= RST_VAL[i];
				end else begin
					s1_q <= pin_in[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						level_q[i] <= s3_q;
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire
